//--- rtl/usb_parallel_fifo_port.sv
`timescale 1ns/100ps
// Byte-wide parallel FIFO port with power, reset and strap handling
module usb_parallel_fifo_port #(
   parameter int RESET_OUT_CYCLES = fifo_port_pkg::RESET_OUT_CYC
) (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              rst,
   // Parallel FIFO bus
   input  wire logic                              rd_n,
   input  wire logic                              wr_n,
   input  wire logic [fifo_port_pkg::DATA_W-1:0]  fifo_data_bus_in,
   output logic      [fifo_port_pkg::DATA_W-1:0]  fifo_data_bus_out,
   output logic                                   fifo_data_bus_oe,
   output logic                                   tx_space_flag_n,
   output logic                                   rx_data_waiting_n,
   // Protocol engine side: host-to-device bytes
   input  wire logic                              rx_in_valid,
   output logic                                   rx_in_ready,
   input  wire logic [fifo_port_pkg::DATA_W-1:0]  rx_in_data,
   // Protocol engine side: device-to-host bytes
   output logic                                   tx_out_valid,
   input  wire logic                              tx_out_ready,
   output logic      [fifo_port_pkg::DATA_W-1:0]  tx_out_data,
   output logic                                   tx_flush_req,
   input  wire logic                              bulk_in_request,
   // Power and wakeup
   input  wire logic                              usb_configured,
   input  wire logic                              usb_suspended,
   input  wire logic                              remote_wake_enabled,
   input  wire logic                              flush_or_wake_strobe_n,
   output logic                                   power_enable_n,
   output logic                                   resume_request,
   // Reset pins
   input  wire logic                              ext_reset_n,
   input  wire logic                              power_good,
   output logic                                   reset_output_n,
   output logic                                   reset_output_oe,
   // Straps and clocks
   input  wire logic                              prom_clock_strap,
   input  wire logic                              prom_select_strap,
   output logic      [15:0]                       product_id,
   output logic                                   clock_48mhz_sel,
   output logic                                   crystal_out,
   input  wire logic                              test_mode
);
   import fifo_port_pkg::*;

   // Two-flop synchronisers; stage one feeds only stage two
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_r <= 3'h7;
         s2_r <= 3'h7;
         s3_r <= 3'h7;
      end else begin
         s1_r <= {flush_or_wake_strobe_n, wr_n, rd_n};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   wire rd_low   = ~s2_r[0];
   wire rd_rise  = s2_r[0] & ~s3_r[0];
   wire wr_fall  = ~s2_r[1] & s3_r[1];
   wire fw_fall  = ~s2_r[2] & s3_r[2];

   // Receive buffer
   logic                  rx_valid;
   logic [DATA_W-1:0]     rx_data;
   stage_fifo #(.WIDTH(DATA_W), .DEPTH(RX_DEPTH)) rx_buf (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (rx_in_valid),
      .in_ready  (rx_in_ready),
      .in_data   (rx_in_data),
      .out_valid (rx_valid),
      .out_ready (rd_rise),
      .out_data  (rx_data),
      .count     ()
   );

   // Bytes land in a small staging FIFO, then move into the large buffer
   logic                  stg_ready;
   logic                  stg_valid;
   logic [DATA_W-1:0]     stg_data;
   logic                  tx_ready;
   logic [DATA_W-1:0]     wr_byte_r;
   logic                  wr_pend_r;
   stage_fifo #(.WIDTH(DATA_W), .DEPTH(STAGE_DEPTH)) tx_stage (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (wr_pend_r),
      .in_ready  (stg_ready),
      .in_data   (wr_byte_r),
      .out_valid (stg_valid),
      .out_ready (tx_ready),
      .out_data  (stg_data),
      .count     ()
   );
   stage_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) tx_buf (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (stg_valid),
      .in_ready  (tx_ready),
      .in_data   (stg_data),
      .out_valid (tx_out_valid),
      .out_ready (tx_out_ready),
      .out_data  (tx_out_data),
      .count     ()
   );

   // The bus data is held by the writer only while the strobe is low, so capture
   // the live bus on the synchronised falling edge
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_byte_r <= '0;
         wr_pend_r <= 1'h0;
      end else if (wr_fall) begin
         wr_byte_r <= fifo_data_bus_in;
         wr_pend_r <= 1'h1;
      end else if (stg_ready) begin
         wr_pend_r <= 1'h0;
      end
   end

   // Flag goes high after each write until the byte is staged and the strobe is high again
   wire tx_busy = wr_pend_r | ~stg_ready | ~s2_r[1];
   always_ff @(posedge clock) begin
      if (rst)
         tx_space_flag_n <= 1'h1;
      else
         tx_space_flag_n <= tx_busy | wr_fall;
   end

   // Read data and flag
   always_ff @(posedge clock) begin
      if (rst) begin
         fifo_data_bus_out <= '0;
         fifo_data_bus_oe  <= 1'h0;
         rx_data_waiting_n <= 1'h1;
      end else begin
         fifo_data_bus_out <= rx_data;
         fifo_data_bus_oe  <= rd_low;
         rx_data_waiting_n <= ~rx_valid | rd_rise;
      end
   end

   // Power enable and flush/wake handling
   always_ff @(posedge clock) begin
      if (rst) begin
         power_enable_n <= 1'h1;
         resume_request <= 1'h0;
         tx_flush_req   <= 1'h0;
      end else begin
         power_enable_n <= ~usb_configured | usb_suspended;
         // Wake only while the power enable shows suspend
         resume_request <= fw_fall & power_enable_n & remote_wake_enabled;
         if (fw_fall && !power_enable_n)
            tx_flush_req <= 1'h1;
         else if (bulk_in_request)
            tx_flush_req <= 1'h0;
      end
   end

   // Reset output sequencer
   reset_out_t  rs_r;
   logic [31:0] rcnt_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         rs_r   <= RST_HIZ;
         rcnt_r <= '0;
      end else if (!ext_reset_n) begin
         rs_r   <= RST_LOW;
         rcnt_r <= '0;
      end else begin
         unique case (rs_r)
            RST_HIZ: begin
               if (!power_good)
                  rcnt_r <= '0;
               else if (rcnt_r >= 32'(RESET_OUT_CYCLES - 1))
                  rs_r <= RST_HIGH;
               else
                  rcnt_r <= rcnt_r + 32'h1;
            end
            RST_LOW: begin
               rs_r   <= RST_HIZ;
               rcnt_r <= '0;
            end
            RST_HIGH: rs_r <= RST_HIGH;
            default:  rs_r <= RST_HIZ;
         endcase
      end
   end
   assign reset_output_n  = (rs_r == RST_HIGH);
   assign reset_output_oe = (rs_r != RST_HIZ);

   // Straps are sampled every cycle while the reset output floats, then held
   always_ff @(posedge clock) begin
      if (rst) begin
         product_id      <= PID_MAIN;
         clock_48mhz_sel <= 1'h0;
      end else if (rs_r == RST_HIZ) begin
         product_id      <= prom_clock_strap ? PID_MAIN : PID_ALT;
         clock_48mhz_sel <= ~prom_select_strap;
      end
   end

   // Crystal output divider, frozen in suspend or test mode
   logic [$clog2(XTAL_DIV)-1:0] xdiv_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         xdiv_r      <= '0;
         crystal_out <= 1'h0;
      end else if (!usb_suspended && !test_mode) begin
         xdiv_r <= xdiv_r + 1'h1;
         if (xdiv_r == '0)
            crystal_out <= ~crystal_out;
      end
   end
endmodule

//--- rtl/fifo_port_pkg.sv
// Constants and types for the parallel FIFO port
// How it works
// - Read strobe low puts the current receive byte on the data bus.
// - Read strobe rising edge advances to the next receive byte if any.
// - Write strobe falling edge captures the data bus into the transmit buffer.
// - Transmit space flag high when full; external logic must then not write.
// - Receive data flag low while a received byte waits, but high for one cycle after each read.
// - Power enable low once configured, high while the bus is suspended.
// - In suspend with wakeup enabled, strobe low requests bus resume.
// - In normal operation, strobe low flushes all transmit bytes next IN request.
// - External reset low forces the reset output to drive low.
// - Reset output floats about 5 ms after power and clock, then drives high.
// - Bus reset does not affect the reset output.
// - Clock strap pulled low selects the alternate product identifier.
// - Select strap pulled low selects 48MHz, otherwise 6MHz operation.
// - Crystal output stops toggling during suspend.
// - Receive buffer holds 128 bytes drained by the read strobe.
// - Transmit buffer holds 384 bytes until the host collects them.
package fifo_port_pkg;
   localparam int DATA_W        = 8;
   localparam int RX_DEPTH      = 128;
   localparam int TX_DEPTH      = 384;
   localparam int STAGE_DEPTH   = 8;
   localparam int CLK_HZ        = 25000000;
   localparam int RESET_OUT_MS  = 5;
   localparam int RESET_OUT_CYC = (CLK_HZ / 1000) * RESET_OUT_MS;
   localparam int XTAL_DIV      = 2;
   localparam logic [15:0] PID_MAIN = 16'h1111;  // Arbitrary value
   localparam logic [15:0] PID_ALT  = 16'h2222;  // Arbitrary value
   typedef enum logic [1:0] {
      RST_HIZ   = 2'b00,
      RST_HIGH  = 2'b01,
      RST_LOW   = 2'b10
   } reset_out_t;
endpackage

//--- rtl/stage_fifo.sv
`timescale 1ns/100ps
// Parameterised flip-flop FIFO with valid/ready on both sides
module stage_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [$clog2(DEPTH+1)-1:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
   endfunction

   assign in_ready  = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign count     = cnt_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data;
            wp_r        <= inc(wp_r);
         end
         if (pop)
            rp_r <= inc(rp_r);
         cnt_r <= cnt_r + (push ? 1'h1 : 1'h0) - (pop ? 1'h1 : 1'h0);
      end
   end
endmodule

//--- sim/usb_parallel_fifo_port_chk.sv
// Concurrent checks on the parallel FIFO port pins
`timescale 1ns/100ps
module usb_parallel_fifo_port_chk #(
   parameter int RESET_OUT_CYCLES = 20
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // FIFO bus
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic fifo_data_bus_oe,
   input wire logic tx_space_flag_n,
   input wire logic rx_data_waiting_n,
   input wire logic tx_flush_req,
   // Power, wakeup and reset
   input wire logic usb_configured,
   input wire logic usb_suspended,
   input wire logic remote_wake_enabled,
   input wire logic flush_or_wake_strobe_n,
   input wire logic power_enable_n,
   input wire logic resume_request,
   input wire logic ext_reset_n,
   input wire logic reset_output_n,
   input wire logic reset_output_oe,
   input wire logic crystal_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Five samples cover the two sync flops plus the output register
   sequence s_rd_idle; rd_n [*5]; endsequence
   sequence s_rd_busy; (!rd_n && !rx_data_waiting_n) [*5]; endsequence
   sequence s_wake;
      $fell(flush_or_wake_strobe_n) && usb_suspended && remote_wake_enabled;
   endsequence
   sequence s_flush; $fell(flush_or_wake_strobe_n) && usb_configured && !usb_suspended; endsequence
   property p_oe_off; s_rd_idle |-> !fifo_data_bus_oe; endproperty
   property p_oe_on; s_rd_busy |-> fifo_data_bus_oe; endproperty
   property p_tx_busy; $fell(wr_n) |-> ##[1:5] tx_space_flag_n; endproperty
   property p_pwr_on; (usb_configured && !usb_suspended) [*3] |-> !power_enable_n; endproperty
   property p_pwr_off; usb_suspended [*3] |-> power_enable_n; endproperty
   property p_wake; s_wake |-> ##[1:10] resume_request; endproperty
   property p_flush; s_flush |-> ##[2:10] tx_flush_req; endproperty
   property p_ext_rst; !ext_reset_n [*5] |-> reset_output_oe && !reset_output_n; endproperty
   property p_xtal; usb_suspended [*4] |-> $stable(crystal_out); endproperty
   a_oe_off:
      assert property (p_oe_off) else $error("data bus driven while read idle");
   a_oe_on:
      assert property (p_oe_on) else $error("data bus not driven during read");
   a_tx_busy:
      assert property (p_tx_busy) else $error("space flag stayed low after write");
   a_pwr_on:
      assert property (p_pwr_on) else $error("power enable not low when configured");
   a_pwr_off:
      assert property (p_pwr_off) else $error("power enable not high in suspend");
   a_wake:
      assert property (p_wake) else $error("no resume after wake strobe");
   a_flush:
      assert property (p_flush) else $error("no flush after strobe");
   a_ext_rst:
      assert property (p_ext_rst) else $error("reset output not driven low");
   a_xtal:
      assert property (p_xtal) else $error("crystal output toggles in suspend");
endmodule
bind usb_parallel_fifo_port usb_parallel_fifo_port_chk #(.RESET_OUT_CYCLES(RESET_OUT_CYCLES))
   usb_parallel_fifo_port_chk_inst (.*);

//--- sim/bus_host_model.sv
// External logic model that strobes the parallel FIFO bus
`timescale 1ns/100ps
module bus_host_model (
   // Clock, flags and resolved bus
   input  wire logic       clock,
   input  wire logic       tx_space_flag_n,
   input  wire logic       rx_data_waiting_n,
   input  wire logic [7:0] fifo_data_bus_in,
   // Strobes and driven data
   output logic            rd_n = 1'h1,
   output logic            wr_n = 1'h1,
   output logic      [7:0] host_data = 8'h00
);
   task automatic wr(input logic [7:0] d, input int hold, output bit ok);
      int k;
      for (k = 0; k < 30 && tx_space_flag_n !== 1'h0; k++) @(negedge clock);
      ok = (k < 30);
      if (ok) begin
         host_data = d;
         wr_n = 1'h0;
         repeat (hold) @(negedge clock);
         wr_n = 1'h1;
         // Released lines must not keep showing the byte
         host_data = ~d;
         repeat (hold) @(negedge clock);
      end
   endtask
   task automatic rd(output logic [7:0] d, input int hold, output bit ok);
      int k;
      for (k = 0; k < 30 && rx_data_waiting_n !== 1'h0; k++) @(negedge clock);
      ok = (k < 30);
      rd_n = !ok;
      repeat (hold) @(negedge clock);
      d = fifo_data_bus_in;
      rd_n = 1'h1;
      // Extra wait lets the flag settle after the pop
      repeat (hold + 2) @(negedge clock);
   endtask
endmodule

//--- sim/usb_parallel_fifo_port_bench.sv
// Self-checking bench for the parallel FIFO port
`timescale 1ns/100ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin errors++; \
   $display("wrong value %0t %s", $time, m); end end
module usb_parallel_fifo_port_bench;
   import fifo_port_pkg::*;
   typedef struct packed {logic ck; logic sel; logic [15:0] pid; logic f48;} strap_row_t;
   logic clock = 1'h0, rst = 1'h1, rx_in_valid = 1'h0, tx_out_ready = 1'h0;
   logic bulk_in_request = 1'h0, usb_configured = 1'h0, usb_suspended = 1'h0;
   logic remote_wake_enabled = 1'h0, flush_or_wake_strobe_n = 1'h1, ext_reset_n = 1'h1;
   logic power_good = 1'h0, prom_clock_strap = 1'h1, prom_select_strap = 1'h1;
   logic test_mode = 1'h0;
   logic [7:0] rx_in_data = 8'h00, tx_out_data, fifo_data_bus_out, host_data, b;
   logic rd_n, wr_n, fifo_data_bus_oe, tx_space_flag_n, rx_data_waiting_n, rx_in_ready;
   logic tx_out_valid, tx_flush_req, power_enable_n, resume_request, reset_output_n;
   logic reset_output_oe, clock_48mhz_sel, crystal_out;
   logic [15:0] product_id;
   wire  [7:0] fifo_data_bus_in = fifo_data_bus_oe ? fifo_data_bus_out : host_data;
   int errors = 0, samples_checked = 0, cycles = 0, n;
   bit ok;
   strap_row_t rows [4] = '{'{1'h1, 1'h1, PID_MAIN, 1'h0}, '{1'h0, 1'h1, PID_ALT, 1'h0},
                            '{1'h1, 1'h0, PID_MAIN, 1'h1}, '{1'h0, 1'h0, PID_ALT, 1'h1}};
   usb_parallel_fifo_port #(.RESET_OUT_CYCLES(20)) usb_parallel_fifo_port_inst (.*);
   bus_host_model bus_host_model_inst (.*);
   always #20 clock = ~clock;
   task automatic close_out();
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Full run is near 6000 cycles, so this only trips on a hang
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         rst = 1'h1;
         power_good = 1'h0;
         prom_clock_strap = rows[i].ck;
         prom_select_strap = rows[i].sel;
         repeat (16) @(negedge clock);
         `CHK({tx_space_flag_n, rx_data_waiting_n, fifo_data_bus_oe}, 3'h6, "reset flags")
         rst = 1'h0;
         power_good = 1'h1;
         repeat (5) @(negedge clock);
         `CHK(reset_output_oe, 1'h0, "reset out early")
         repeat (40) @(negedge clock);
         `CHK({reset_output_oe, reset_output_n}, 2'h3, "reset out high")
         `CHK(product_id, rows[i].pid, "product id")
         `CHK(clock_48mhz_sel, rows[i].f48, "clock select")
      end
      ext_reset_n = 1'h0;
      repeat (6) @(negedge clock);
      `CHK({reset_output_oe, reset_output_n}, 2'h2, "ext reset")
      ext_reset_n = 1'h1;
      usb_configured = 1'h1;
      repeat (30) @(negedge clock);
      `CHK(power_enable_n, 1'h0, "power on")
      n = 0;
      rx_in_valid = 1'h1;
      for (n = 0; n < 200 && rx_in_ready === 1'h1; n++) begin
         rx_in_data = n[7:0];
         @(negedge clock);
      end
      rx_in_valid = 1'h0;
      `CHK(n, RX_DEPTH, "rx depth")
      `CHK(rx_data_waiting_n, 1'h0, "rx flag")
      // Half prompt, half slow strobes
      for (int i = 0; i < RX_DEPTH; i++) begin
         bus_host_model_inst.rd(b, (i < 64) ? 4 : 8, ok);
         `CHK({ok, b}, {1'h1, i[7:0]}, "rx order")
      end
      `CHK({rx_data_waiting_n, fifo_data_bus_oe}, 2'h2, "rx empty")
      ok = 1'h1;
      for (n = 0; ok && n < 500; n += ok) bus_host_model_inst.wr(n[7:0], 4, ok);
      // The staging words add to the large buffer before the flag stays high
      `CHK(n, TX_DEPTH + STAGE_DEPTH, "tx depth")
      tx_out_ready = 1'h1;
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 20 && tx_out_valid !== 1'h1; k++) @(negedge clock);
         `CHK({tx_out_valid, tx_out_data}, {1'h1, i[7:0]}, "tx order")
         @(negedge clock);
      end
      repeat (4) @(negedge clock);
      `CHK(tx_space_flag_n, 1'h0, "tx space")
      flush_or_wake_strobe_n = 1'h0;
      repeat (4) @(negedge clock);
      flush_or_wake_strobe_n = 1'h1;
      repeat (8) @(negedge clock);
      `CHK(tx_flush_req, 1'h1, "flush set")
      bulk_in_request = 1'h1;
      @(negedge clock);
      bulk_in_request = 1'h0;
      @(negedge clock);
      `CHK(tx_flush_req, 1'h0, "flush clear")
      b[1] = crystal_out;
      repeat (XTAL_DIV) @(negedge clock);
      `CHK(crystal_out, ~b[1], "crystal run")
      usb_suspended = 1'h1;
      remote_wake_enabled = 1'h1;
      repeat (4) @(negedge clock);
      `CHK(power_enable_n, 1'h1, "suspend power")
      b[0] = crystal_out;
      repeat (5) @(negedge clock);
      `CHK(crystal_out, b[0], "crystal stop")
      n = 0;
      flush_or_wake_strobe_n = 1'h0;
      for (int k = 0; k < 14; k++) begin
         @(negedge clock);
         if (k == 4) flush_or_wake_strobe_n = 1'h1;
         if (resume_request === 1'h1) n++;
      end
      `CHK(n, 1, "resume pulse")
      close_out();
   end
endmodule
